// ===== src/fbp_consts.svh
// Offsets, field positions and reset values of the five-bit port.
// Assumes inclusion by bare name from the package and the port module.
`ifndef FBP_CONSTS_SVH
`define FBP_CONSTS_SVH
// Register indices; byte address is four times the index
`define FBP_DDR_IDX 16'hffcd
`define FBP_DR_IDX 16'hffcf
`define FBP_CTL_IDX 16'hffc0
// Reset values of the direction register per mode group
`define FBP_DDR_RST_A 8'hf0
`define FBP_DDR_RST_B 8'he0
// Reset value of the data register in every mode
`define FBP_DR_RST 8'he0
// Control register fields
`define FBP_CTL_RFE 0
`define FBP_CTL_IEN_LSB 4
`define FBP_CTL_RST 8'h00
// Read value of a write-only register
`define FBP_ALL_ONES 8'hff
`endif

// ===== src/fbp_pkg.sv
// Types shared by the five-bit port.
// Assumes the constants header sits beside it.
`include "fbp_consts.svh"
package fbp_pkg;
  // Operating mode group, caught from the mode strap at reset
  typedef enum logic [1:0] {
    FBP_SINGLE = 2'b00,
    FBP_EXP_NOROM = 2'b01,
    FBP_EXP_ROM = 2'b11
  } fbp_mode_t;
  // One bit per port pin
  typedef logic [4:0] fbp_pins_t;
endpackage : fbp_pkg

// ===== src/fbp_port.sv
// Five-pin general-purpose port with chip-select and refresh outputs.
// Assumes an APB master on SYS_CLK, chip selects and refresh strobe
// from the bus controller, and pin buffers resolved outside.
//
// Functional notes
// RQ1: Five pins, bits 4..0, each input or output
// RQ2: Single-chip mode: direction bit selects output
// RQ3: Expanded: direction bits 4..1 give chip selects
// RQ4: Modes 1-4 reset: only pin 4 drives select
// RQ5: Modes 5-6 reset: select pins are inputs
// RQ6: Refresh enable forces refresh strobe on pin 0; here only in expanded modes, single-chip ignores it
// RQ7: Pins 3..0 feed enabled interrupt inputs
// RQ8: Direction register write-only, reads all ones
// RQ9: Direction reset F0 modes 1-4, E0 otherwise
// RQ10: Software standby keeps direction and outputs
// RQ11: Data register drives general-purpose output pins
// RQ12: Data read: stored bit or live pin
// RQ13: Bits 7..5 reserved, ignored, read as ones
// RQ14: Data register resets to E0, holds otherwise; here hardware standby also reloads it to E0
// RQ15: Writes act at access; pin inputs synchronised
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "fbp_consts.svh"
module fbp_port
  import fbp_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [2:0] MODE,
  input wire logic HW_STANDBY,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [3:0] CS_N_IN,
  input wire logic REFRESH_STROBE_N_IN,
  input wire logic [4:0] PIN_IN,
  output logic [4:0] PIN_OUT,
  output logic [4:0] PIN_OE,
  output logic [3:0] IRQ_OUT
);

  // Refuse an address bus too narrow for the highest index
  if (ADDR_W < 18) begin : g_addr_chk
    $error("fbp_port: ADDR_W must be at least 18");
  end

  // Register state
  fbp_mode_t mode_q;
  fbp_mode_t mode_d;
  fbp_pins_t ddr_q;
  fbp_pins_t dr_q;
  logic [7:0] ctl_q;
  fbp_pins_t pin_s1_q;
  fbp_pins_t pin_s2_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  fbp_pins_t out_q;
  fbp_pins_t oe_q;
  logic [3:0] irq_q;
  logic [2:0] mode_s1_q;
  logic [2:0] mode_s2_q;
  logic stby_s1_q;
  logic stby_s2_q;

  // Decoded bus and mode signals
  wire logic [15:0] idx = PADDR[17:2];
  wire logic hit_ddr = idx == `FBP_DDR_IDX;
  wire logic hit_dr = idx == `FBP_DR_IDX;
  wire logic hit_ctl = idx == `FBP_CTL_IDX;
  wire logic hit_any = hit_ddr | hit_dr | hit_ctl;
  wire logic setup = PSEL & ~PENABLE;
  wire logic access = PSEL & PENABLE & pready_q;
  wire logic wr_lane = access & PWRITE & PSTRB[0];
  wire logic wr_ddr = wr_lane & hit_ddr;
  wire logic wr_dr = wr_lane & hit_dr;
  wire logic wr_ctl = wr_lane & hit_ctl;
  wire logic expanded = mode_q != FBP_SINGLE;
  wire logic rfe = ctl_q[`FBP_CTL_RFE];
  wire logic [3:0] irq_en = ctl_q[`FBP_CTL_IEN_LSB +: 4];
  wire logic class_a = (mode_s2_q >= 3'h1) && (mode_s2_q <= 3'h4);
  wire logic class_b = (mode_s2_q == 3'h5) || (mode_s2_q == 3'h6);
  wire logic grp_a = SRST ? class_a : (mode_q == FBP_EXP_NOROM);
  wire logic [7:0] ddr_rst = grp_a ? `FBP_DDR_RST_A : // RQ4
                             `FBP_DDR_RST_B; // RQ5
  wire logic [7:0] dr_rst = `FBP_DR_RST;
  wire logic [7:0] ones = `FBP_ALL_ONES;
  wire logic clear_port = SRST | stby_s2_q;

  // Mode group from the strap
  assign mode_d = class_a ? FBP_EXP_NOROM :
                  class_b ? FBP_EXP_ROM :
                  FBP_SINGLE;

  // Data read: stored bit where output, synchronised pin where input
  wire fbp_pins_t dr_view = (ddr_q & dr_q) | (~ddr_q & pin_s2_q); // RQ12
  wire logic [7:0] rd_dr = {ones[7:5], dr_view}; // RQ13
  wire logic [7:0] rd_byte = hit_ddr ? ones : // RQ8
                             hit_dr ? rd_dr :
                             hit_ctl ? ctl_q : 8'h00;

  // Per-pin function select, combinational before the output flops
  fbp_pins_t out_d;
  fbp_pins_t oe_d;
  for (genvar i = 0; i < 5; i++) begin : g_pin // RQ1
    if (i == 0) begin : g_refresh
      // Refresh strobe takes pin 0 regardless of direction
      assign oe_d[i] = (expanded & rfe) | ddr_q[i]; // RQ6
      assign out_d[i] = (expanded & rfe) ? REFRESH_STROBE_N_IN : dr_q[i];
    end else begin : g_cs
      // Pins 4..1 carry chip selects 0..3 in expanded modes
      assign oe_d[i] = ddr_q[i]; // RQ2
      assign out_d[i] = expanded ? CS_N_IN[4-i] : dr_q[i]; // RQ3
    end
  end

  // Mode group is caught while reset is held
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      mode_q <= mode_d;
    end
  end

  // Direction register; reset and hardware standby reload it
  always_ff @(posedge SYS_CLK) begin
    if (clear_port) begin
      ddr_q <= ddr_rst[4:0]; // RQ9
    end else if (wr_ddr) begin
      ddr_q <= PWDATA[4:0]; // RQ15
    end
  end

  // Data register; upper bits are not stored
  always_ff @(posedge SYS_CLK) begin
    if (clear_port) begin
      dr_q <= dr_rst[4:0]; // RQ14
    end else if (wr_dr) begin
      dr_q <= PWDATA[4:0]; // RQ11
    end
  end

  // Control register: refresh enable and interrupt enables
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctl_q <= `FBP_CTL_RST;
    end else if (wr_ctl) begin
      ctl_q <= PWDATA[7:0];
    end
  end

  // Two-flop synchroniser on the pin levels
  always_ff @(posedge SYS_CLK) begin
    pin_s1_q <= PIN_IN;
    pin_s2_q <= pin_s1_q; // RQ15
  end

  // Strap and hardware standby come from pins: two flops each
  always_ff @(posedge SYS_CLK) begin
    mode_s1_q <= MODE;
    mode_s2_q <= mode_s1_q;
    stby_s1_q <= HW_STANDBY;
    stby_s2_q <= stby_s1_q; // RQ9
  end

  // Pin drivers and interrupt feed, all registered
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      out_q <= 5'h1f;
      oe_q <= 5'h00;
      irq_q <= 4'h0;
    end else begin
      out_q <= out_d; // RQ11
      oe_q <= oe_d; // RQ10
      irq_q <= pin_s2_q[3:0] & irq_en; // RQ7
    end
  end

  // APB slave: no wait states, read data caught in setup
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      prdata_q <= (setup & ~PWRITE) ? {24'h00_0000, rd_byte} :
                  32'h0000_0000;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PIN_OUT = out_q;
  assign PIN_OE = oe_q;
  assign IRQ_OUT = irq_q;

  // Checks on the port behaviour

  // Direction reads give all ones
  a_ddr_read_ones: assert property ( // RQ8
    @(posedge SYS_CLK) disable iff (SRST)
    (setup && !PWRITE && hit_ddr) |=> (PRDATA[7:0] == 8'hff))
    else $error("direction read not all ones");

  // Reserved data bits read as ones
  a_dr_reserved_ones: assert property ( // RQ13
    @(posedge SYS_CLK) disable iff (SRST)
    (setup && !PWRITE && hit_dr) |=> (PRDATA[7:5] == 3'h7))
    else $error("reserved data bits not ones");

  // Data read mixes stored bits and pin levels
  a_dr_read_mix: assert property ( // RQ12
    @(posedge SYS_CLK) disable iff (SRST)
    (setup && !PWRITE && hit_dr) |=>
      (PRDATA[4:0] == (($past(ddr_q) & $past(dr_q)) |
                       (~$past(ddr_q) & $past(pin_s2_q)))))
    else $error("data read mix wrong");

  // Chip select 0 reaches pin 4 when enabled
  a_cs_pin_map: assert property ( // RQ3
    @(posedge SYS_CLK) disable iff (SRST)
    (expanded && ddr_q[4]) |=>
      (PIN_OE[4] && PIN_OUT[4] == $past(CS_N_IN[0])))
    else $error("chip select 0 not on pin 4");

  // Chip select 3 reaches pin 1 when enabled
  a_cs_last_pin: assert property ( // RQ3
    @(posedge SYS_CLK) disable iff (SRST)
    (expanded && ddr_q[1]) |=>
      (PIN_OE[1] && PIN_OUT[1] == $past(CS_N_IN[3])))
    else $error("chip select 3 not on pin 1");

  // Refresh strobe owns pin 0 while enabled
  a_refresh_pin: assert property ( // RQ6
    @(posedge SYS_CLK) disable iff (SRST)
    (expanded && rfe && !ddr_q[0]) |=>
      (PIN_OE[0] && PIN_OUT[0] == $past(REFRESH_STROBE_N_IN)))
    else $error("refresh strobe missing on pin 0");

  // Single-chip output pin 2 follows the data register
  a_gpio_drive: assert property ( // RQ2
    @(posedge SYS_CLK) disable iff (SRST)
    (!expanded && ddr_q[2]) |=> (PIN_OE[2] && PIN_OUT[2] == $past(dr_q[2])))
    else $error("general output not driven");

  // Input pin 3 is not driven
  a_input_float: assert property ( // RQ2
    @(posedge SYS_CLK) disable iff (SRST)
    (!ddr_q[3]) |=> !PIN_OE[3])
    else $error("input pin driven");

  // Direction reset value per mode group
  a_ddr_reset: assert property ( // RQ9
    @(posedge SYS_CLK) disable iff (SRST)
    $fell(SRST) |->
      (ddr_q == ((mode_q == FBP_EXP_NOROM) ? 5'h10 : 5'h00)))
    else $error("direction reset value wrong");

  // Data reset value
  a_dr_reset: assert property ( // RQ14
    @(posedge SYS_CLK) disable iff (SRST)
    $fell(SRST) |-> (dr_q == 5'h00))
    else $error("data reset value wrong");

  // Write lands at the access edge
  a_write_takes: assert property ( // RQ15
    @(posedge SYS_CLK) disable iff (SRST)
    (wr_dr && !stby_s2_q) |=> (dr_q == $past(PWDATA[4:0])))
    else $error("data write lost");

  // State holds with no write and no hardware standby
  a_state_hold: assert property ( // RQ10
    @(posedge SYS_CLK) disable iff (SRST)
    (!wr_ddr && !wr_dr && !stby_s2_q) |=> ($stable(ddr_q) && $stable(dr_q)))
    else $error("port state changed unasked");

  // Interrupt inputs follow enabled synchronised pins one cycle on
  a_irq_feed: assert property ( // RQ7
    @(posedge SYS_CLK) disable iff (SRST)
    !$past(SRST) |-> (IRQ_OUT == ($past(pin_s2_q[3:0]) & $past(irq_en))))
    else $error("interrupt feed wrong");

  // Answer comes one cycle after setup
  a_apb_wait: assert property ( // RQ15
    @(posedge SYS_CLK) disable iff (SRST)
    setup |=> PREADY ##1 !PREADY)
    else $error("ready timing wrong");

  // Modes 1-4 come out of reset with only pin 4 driving select 0
  a_reset_cs_zero: assert property ( // RQ4
    @(posedge SYS_CLK) disable iff (SRST)
    ($fell(SRST) && mode_q == FBP_EXP_NOROM) |=>
      (PIN_OE == 5'h10 && PIN_OUT[4] == $past(CS_N_IN[0])))
    else $error("reset select 0 missing");

  // Modes 5-6 come out of reset with every select pin an input
  a_reset_cs_none: assert property ( // RQ5
    @(posedge SYS_CLK) disable iff (SRST)
    ($fell(SRST) && mode_q == FBP_EXP_ROM) |=> (PIN_OE == 5'h00))
    else $error("select pin driven after reset");

  // Pin 0 without refresh drives the stored data bit
  a_gpio_data: assert property ( // RQ11
    @(posedge SYS_CLK) disable iff (SRST)
    (!(expanded && rfe) && ddr_q[0]) |=>
      (PIN_OE[0] && PIN_OUT[0] == $past(dr_q[0])))
    else $error("data bit not on pin 0");

  // Hardware standby reloads both registers
  a_standby_reload: assert property ( // RQ9
    @(posedge SYS_CLK) disable iff (SRST)
    stby_s2_q |=>
      (dr_q == 5'h00 &&
       ddr_q == ((mode_q == FBP_EXP_NOROM) ? 5'h10 : 5'h00)))
    else $error("standby reload wrong");

  // Masked interrupt inputs stay low
  a_irq_masked: assert property ( // RQ7
    @(posedge SYS_CLK) disable iff (SRST)
    (irq_en == 4'h0) |=> (IRQ_OUT == 4'h0))
    else $error("masked interrupt raised");

  // Error only ever comes with the answer
  a_err_with_ready: assert property ( // RQ15
    @(posedge SYS_CLK) disable iff (SRST)
    PSLVERR |-> PREADY)
    else $error("error without ready");

  // Clearing direction bit 4 makes pin 4 an input
  a_cs_pin_input: assert property ( // RQ3
    @(posedge SYS_CLK) disable iff (SRST)
    (!ddr_q[4]) |=> !PIN_OE[4])
    else $error("pin 4 driven as input");

endmodule : fbp_port

// ===== test/fbp_pin_partner.sv
// Far side of the port pins: devices that listen or drive the lines.
// Assumes no pull resistors; an undriven pin shows the bench pattern.
`timescale 1ns/100ps
module fbp_pin_partner (
  input wire logic [4:0] oe,
  input wire logic [4:0] out,
  input wire logic [4:0] ext,
  output logic [4:0] pin
);
  // A driven pin shows the port value, else the far side value
  assign pin = (oe & out) | (~oe & ext);
endmodule : fbp_pin_partner

// ===== test/tb_top.sv
// Self-checking bench of the five-bit port over APB.
// Assumes the port package, constants header and pin partner.
`timescale 1ns/100ps
`include "fbp_consts.svh"
`define CHK(n, x, g) begin check_count++; if ((g) !== (x)) begin \
  fail_count++; $display("[FAIL] %s exp %h got %h", n, x, g); end end
module tb_top;
  import fbp_pkg::*;
  localparam logic [17:0] A_DDR = {`FBP_DDR_IDX, 2'b00};
  localparam logic [17:0] A_DR = {`FBP_DR_IDX, 2'b00};
  localparam logic [17:0] A_CTL = {`FBP_CTL_IDX, 2'b00};
  logic clk = 0, srst = 1, stby = 0, psel = 0, pen = 0, pwr = 0;
  logic refr_n = 1, pready, pslverr;
  logic [2:0] mode = 3'd7;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] cs_n = 4'ha, irq;
  logic [4:0] ext = '0, pin_in, pin_out, pin_oe, mix;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int fail_count = 0, check_count = 0;
  always #25 clk = ~clk;
  fbp_port i_dut (.SYS_CLK(clk), .SRST(srst), .MODE(mode),
    .HW_STANDBY(stby), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'h1), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CS_N_IN(cs_n),
    .REFRESH_STROBE_N_IN(refr_n), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .IRQ_OUT(irq));
  fbp_pin_partner i_far (.oe(pin_oe), .out(pin_out), .ext(ext),
    .pin(pin_in));
  // Ends the run with the verdict
  task end_of_test;
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // One APB transfer; ex holds {check data, error, data}
  task xfer(input logic w, input logic [17:0] a, input logic [7:0] d,
            input logic [33:0] ex);
    exp_q.push_back(ex);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    pen <= 1'b1;
    // Wait ends once pready is seen high; the watchdog ends a stall
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task rd(input logic [17:0] a, input logic [7:0] x);
    xfer(0, a, 8'h0, {2'b10, 24'h0, x});
  endtask : rd
  task rst(input logic [2:0] m);
    srst <= 1;
    mode <= m;
    repeat (8) @(posedge clk);
    srst <= 0;
    repeat (4) @(posedge clk);
  endtask : rst
  // Takes the oldest note whenever an answer appears
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      e = exp_q.pop_front();
      `CHK("pslverr", e[32], pslverr)
      if (e[33]) `CHK("prdata", e[31:0], prdata)
    end
  end
  // Watchdog
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h9bfe));
    ext <= 5'($urandom);
    rst(3'd7);
    `CHK("oe7", 5'h00, pin_oe)
    rd(A_DDR, 8'hff);
    rd(A_DR, {3'b111, ext});
    xfer(1, A_DDR, 8'h1f, '0);
    xfer(1, A_DR, 8'h15, '0);
    rd(A_DR, 8'hf5);
    `CHK("oe", 5'h1f, pin_oe)
    `CHK("out", 5'h15, pin_out)
    xfer(1, A_DDR, 8'h05, '0);
    ext <= 5'($urandom);
    repeat (4) @(posedge clk);
    mix = 5'h05 & 5'h15 | ~5'h05 & ext;
    rd(A_DR, {3'b111, mix});
    xfer(0, 18'h3ff10, 8'h0, {2'b01, 32'h0});
    xfer(1, A_CTL, 8'hf0, '0);
    repeat (4) @(posedge clk);
    `CHK("irq", mix[3:0], irq)
    xfer(1, A_CTL, 8'h00, '0);
    repeat (4) @(posedge clk);
    `CHK("irq0", 4'h0, irq)
    stby <= 1;
    repeat (2) @(posedge clk);
    stby <= 0;
    repeat (4) @(posedge clk);
    `CHK("oes", 5'h00, pin_oe)
    rd(A_DR, {3'b111, ext});
    for (int m = 1; m < 7; m++) begin
      rst(3'(m));
      `CHK("oem", (m <= 4) ? 5'h10 : 5'h00, pin_oe)
      rd(A_DR, {3'b111, ext & ((m <= 4) ? 5'h0f : 5'h1f)});
      xfer(1, A_DDR, 8'h1e, '0);
      cs_n <= 4'($urandom);
      refr_n <= 1'b0;
      xfer(1, A_CTL, 8'h01, '0);
      repeat (3) @(posedge clk);
      `CHK("oecs", 5'h1f, pin_oe)
      `CHK("cs", {cs_n[0], cs_n[1], cs_n[2], cs_n[3], 1'b0}, pin_out)
    end
    end_of_test();
  end
endmodule : tb_top
